/* File: rtl/rxpc_pkg.sv */
// package for the receive phase compensation fifo and read clock selection
package rxpc_pkg;

	// channel and fifo geometry
	localparam int NUM_CH = 4;
	localparam int DATA_W = 16;
	localparam int STAT_W = 4;
	localparam int FIFO_AW = 3;
	localparam int FIFO_DEPTH = 8;
	localparam int NUM_TICK = 14;

	// register offsets
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_STATUS = 4'h4;
	localparam logic [3:0] OFS_MASK = 4'h8;
	localparam logic [3:0] OFS_SEL = 4'hC;

	// control register fields
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_USER_LSB = 4;
	localparam int CTRL_RM_BIT = 8;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0100;
	localparam logic [31:0] MASK_RESET = 32'h0000_0000;

	// status register fields
	localparam int STAT_OVF_LSB = 0;
	localparam int STAT_UNF_LSB = 4;

	// select readback fields
	localparam int SEL_FIELD_W = 4;
	localparam int SEL_IDENT_LSB = 16;

	// tick vector positions
	localparam int TICK_TX_LSB = 0;
	localparam int TICK_RX_LSB = 4;
	localparam int TICK_USER_LSB = 8;
	localparam int TICK_CORE_LOCAL = 12;
	localparam int TICK_CORE_MASTER = 13;

	// channel bonding configuration
	typedef enum logic [1:0] {
		MODE_NONBOND,
		MODE_BOND_X4,
		MODE_BOND_X8,
		MODE_SPARE
	} rxpc_mode_e;

	// chosen fifo read clock source
	typedef enum logic [2:0] {
		SRC_TX_OWN,
		SRC_TX_CH0,
		SRC_TX_CH2,
		SRC_RX_OWN,
		SRC_CORE_LOCAL,
		SRC_CORE_MASTER,
		SRC_USER
	} rxpc_src_e;

	// per-channel setup used for the identity check
	typedef struct packed {
		logic [3:0] refclk_src;
		logic pll_second;
		logic [7:0] pll_cfg;
		logic [15:0] pma_pcs_cfg;
	} rxpc_cfg_s;

	// one receive word with its status
	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic [STAT_W-1:0] status;
	} rxpc_word_s;

endpackage

/* File: rtl/rxpc_fifo_rdclk.sv */
// receive phase compensation fifos with automatic or user read clock selection
//
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/1ps

module rxpc_fifo_rdclk (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire rxpc_pkg::rxpc_cfg_s [rxpc_pkg::NUM_CH-1:0] chan_cfg,
	input wire rxpc_pkg::rxpc_word_s [rxpc_pkg::NUM_CH-1:0] wr_word,
	input wire logic [rxpc_pkg::NUM_CH-1:0] wr_valid,
	input wire logic [rxpc_pkg::NUM_CH-1:0] tx_par_clk,
	input wire logic [rxpc_pkg::NUM_CH-1:0] rx_rec_clk,
	input wire logic [rxpc_pkg::NUM_CH-1:0] user_rd_clk,
	input wire logic core_clk_local,
	input wire logic core_clk_master,
	output rxpc_pkg::rxpc_word_s [rxpc_pkg::NUM_CH-1:0] rd_word,
	output logic [rxpc_pkg::NUM_CH-1:0] rd_valid,
	output rxpc_pkg::rxpc_src_e [rxpc_pkg::NUM_CH-1:0] rd_src,
	output logic [rxpc_pkg::NUM_CH-1:0] rate_match_on,
	output logic irq
);

	////////////////////////////////////////////////////////////////////////////
	// declarations

	// register file state
	logic [31:0] ctrl_q;
	logic [31:0] mask_q;
	logic [31:0] status_q;
	logic [31:0] status_d;
	logic [31:0] status_set;
	logic [31:0] rdata_d;

	// candidate clocks turned into ticks
	logic [rxpc_pkg::NUM_TICK-1:0] raw_tick;
	logic [rxpc_pkg::NUM_TICK-1:0] sync1_q;
	logic [rxpc_pkg::NUM_TICK-1:0] sync2_q;
	logic [rxpc_pkg::NUM_TICK-1:0] sync3_q;
	logic [rxpc_pkg::NUM_TICK-1:0] tick;

	// read clock selection
	rxpc_pkg::rxpc_src_e [rxpc_pkg::NUM_CH-1:0] src_d;
	rxpc_pkg::rxpc_src_e [rxpc_pkg::NUM_CH-1:0] src_q;
	logic [rxpc_pkg::NUM_CH-1:0] rm_d;
	logic [rxpc_pkg::NUM_CH-1:0] rm_q;

	// per-channel fifo events
	logic [rxpc_pkg::NUM_CH-1:0] rd_tick;
	logic [rxpc_pkg::NUM_CH-1:0] ovf_ev;
	logic [rxpc_pkg::NUM_CH-1:0] unf_ev;

	// registered outputs
	logic [rxpc_pkg::NUM_CH-1:0] rd_valid_q;
	rxpc_pkg::rxpc_word_s [rxpc_pkg::NUM_CH-1:0] rd_word_q;
	logic irq_q;

	// identity and control decode
	logic all_ident;
	logic pair_ident;
	logic [2:0] ident_vec;
	rxpc_pkg::rxpc_mode_e mode;
	logic [rxpc_pkg::NUM_CH-1:0] user_en;
	logic rm_nonbond;

	////////////////////////////////////////////////////////////////////////////
	// functions

	// two channels match on refclk source, pll setup and pma/pcs setup
	function automatic logic chan_same(input rxpc_pkg::rxpc_cfg_s a, input rxpc_pkg::rxpc_cfg_s b);
		chan_same = (a.refclk_src == b.refclk_src) && (a.pll_second == b.pll_second) &&
			(a.pll_cfg == b.pll_cfg) && (a.pma_pcs_cfg == b.pma_pcs_cfg);
	endfunction

	// read tick of one channel for a given source
	function automatic logic pick_tick(input rxpc_pkg::rxpc_src_e s, input int ch,
		input logic [rxpc_pkg::NUM_TICK-1:0] t);
		pick_tick = 1'b0;
		unique case (s)
			rxpc_pkg::SRC_TX_OWN: pick_tick = t[rxpc_pkg::TICK_TX_LSB + ch];
			rxpc_pkg::SRC_TX_CH0: pick_tick = t[rxpc_pkg::TICK_TX_LSB];
			rxpc_pkg::SRC_TX_CH2: pick_tick = t[rxpc_pkg::TICK_TX_LSB + 2];
			rxpc_pkg::SRC_RX_OWN: pick_tick = t[rxpc_pkg::TICK_RX_LSB + ch];
			rxpc_pkg::SRC_CORE_LOCAL: pick_tick = t[rxpc_pkg::TICK_CORE_LOCAL];
			rxpc_pkg::SRC_CORE_MASTER: pick_tick = t[rxpc_pkg::TICK_CORE_MASTER];
			rxpc_pkg::SRC_USER: pick_tick = t[rxpc_pkg::TICK_USER_LSB + ch];
			default: pick_tick = 1'b0;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// control fields

	assign mode = rxpc_pkg::rxpc_mode_e'(ctrl_q[rxpc_pkg::CTRL_MODE_LSB +: 2]);
	assign user_en = ctrl_q[rxpc_pkg::CTRL_USER_LSB +: rxpc_pkg::NUM_CH];
	assign rm_nonbond = ctrl_q[rxpc_pkg::CTRL_RM_BIT];

	////////////////////////////////////////////////////////////////////////////
	// clock source synchronisers

	// foreign clocks are sampled and edge detected into one-cycle ticks
	assign raw_tick = {core_clk_master, core_clk_local, user_rd_clk, rx_rec_clk, tx_par_clk};

	genvar gi;
	generate
		for (gi = 0; gi < rxpc_pkg::NUM_TICK; gi++) begin : g_sync
			// two-stage synchroniser plus edge history
			always_ff @(posedge clk_sys or posedge rst) begin
				if (rst) begin
					sync1_q[gi] <= 1'b0;
					sync2_q[gi] <= 1'b0;
					sync3_q[gi] <= 1'b0;
				end else begin
					sync1_q[gi] <= raw_tick[gi];
					sync2_q[gi] <= sync1_q[gi];
					sync3_q[gi] <= sync2_q[gi];
				end
			end
			assign tick[gi] = sync2_q[gi] & ~sync3_q[gi];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// read clock selection

	// identity of the whole block and of the two pll pairs
	always_comb begin
		ident_vec[0] = chan_same(chan_cfg[0], chan_cfg[1]);
		ident_vec[1] = chan_same(chan_cfg[1], chan_cfg[2]);
		ident_vec[2] = chan_same(chan_cfg[2], chan_cfg[3]);
		all_ident = &ident_vec;
		pair_ident = ident_vec[0] && ident_vec[2] && !chan_cfg[0].pll_second &&
			chan_cfg[2].pll_second;
	end

	// per-channel source choice from mode, identity and user override
	always_comb begin
		for (int ch = 0; ch < rxpc_pkg::NUM_CH; ch++) begin
			src_d[ch] = rxpc_pkg::SRC_TX_OWN;
			rm_d[ch] = rm_nonbond;
			unique case (mode)
				rxpc_pkg::MODE_BOND_X4: begin
					src_d[ch] = rxpc_pkg::SRC_CORE_LOCAL;
					rm_d[ch] = 1'b1;
				end
				rxpc_pkg::MODE_BOND_X8: begin
					src_d[ch] = rxpc_pkg::SRC_CORE_MASTER;
					rm_d[ch] = 1'b1;
				end
				default: begin
					if (!rm_nonbond) begin
						src_d[ch] = rxpc_pkg::SRC_RX_OWN;
					end else if (all_ident) begin
						src_d[ch] = rxpc_pkg::SRC_TX_CH0;
					end else if (pair_ident) begin
						src_d[ch] = (ch < 2) ? rxpc_pkg::SRC_TX_CH0 : rxpc_pkg::SRC_TX_CH2;
					end else begin
						src_d[ch] = rxpc_pkg::SRC_TX_OWN;
					end
				end
			endcase
			if (user_en[ch]) begin
				src_d[ch] = rxpc_pkg::SRC_USER;
			end
		end
	end

	// registered selection, also published to the fabric
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			src_q <= '{default: rxpc_pkg::SRC_TX_OWN};
			rm_q <= {rxpc_pkg::NUM_CH{1'b1}};
		end else begin
			src_q <= src_d;
			rm_q <= rm_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// phase compensation fifos

	generate
		for (gi = 0; gi < rxpc_pkg::NUM_CH; gi++) begin : g_fifo
			rxpc_pkg::rxpc_word_s mem [rxpc_pkg::FIFO_DEPTH];
			logic [rxpc_pkg::FIFO_AW:0] wptr_q;
			logic [rxpc_pkg::FIFO_AW:0] rptr_q;
			logic full;
			logic empty;
			logic do_wr;
			logic do_rd;

			// read tick of this channel's chosen clock
			assign rd_tick[gi] = pick_tick(src_q[gi], gi, tick);

			// extra pointer bit tells full from empty
			assign empty = (wptr_q == rptr_q);
			assign full = (wptr_q[rxpc_pkg::FIFO_AW-1:0] == rptr_q[rxpc_pkg::FIFO_AW-1:0]) &&
				(wptr_q[rxpc_pkg::FIFO_AW] != rptr_q[rxpc_pkg::FIFO_AW]);

			// refused transfers leave the pointers alone
			assign do_wr = wr_valid[gi] && !full;
			assign do_rd = rd_tick[gi] && !empty;

			// refused transfers only raise flags
			assign ovf_ev[gi] = wr_valid[gi] && full;
			assign unf_ev[gi] = rd_tick[gi] && empty;

			// storage, written on the pcs side
			always_ff @(posedge clk_sys) begin
				if (do_wr) begin
					mem[wptr_q[rxpc_pkg::FIFO_AW-1:0]] <= wr_word[gi];
				end
			end

			// write pointer
			always_ff @(posedge clk_sys or posedge rst) begin
				if (rst) begin
					wptr_q <= '0;
				end else if (do_wr) begin
					wptr_q <= wptr_q + 1'b1;
				end
			end

			// read pointer and output word on the selected read tick
			always_ff @(posedge clk_sys or posedge rst) begin
				if (rst) begin
					rptr_q <= '0;
					rd_word_q[gi] <= '0;
					rd_valid_q[gi] <= 1'b0;
				end else begin
					rd_valid_q[gi] <= do_rd;
					if (do_rd) begin
						rptr_q <= rptr_q + 1'b1;
						rd_word_q[gi] <= mem[rptr_q[rxpc_pkg::FIFO_AW-1:0]];
					end
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// register file

	// control and mask writes
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ctrl_q <= rxpc_pkg::CTRL_RESET;
			mask_q <= rxpc_pkg::MASK_RESET;
		end else if (reg_wr) begin
			if (reg_addr == rxpc_pkg::OFS_CTRL) begin
				ctrl_q <= reg_wdata & 32'h0000_01F3;
			end
			if (reg_addr == rxpc_pkg::OFS_MASK) begin
				mask_q <= reg_wdata & 32'h0000_00FF;
			end
		end
	end

	// sticky error flags, cleared by reading, a new event wins
	always_comb begin
		status_set = '0;
		status_set[rxpc_pkg::STAT_OVF_LSB +: rxpc_pkg::NUM_CH] = ovf_ev;
		status_set[rxpc_pkg::STAT_UNF_LSB +: rxpc_pkg::NUM_CH] = unf_ev;
		status_d = status_q;
		if (reg_rd && (reg_addr == rxpc_pkg::OFS_STATUS)) begin
			status_d = '0;
		end
		status_d = status_d | status_set;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			status_q <= '0;
		end else begin
			status_q <= status_d;
		end
	end

	// read data mux
	always_comb begin
		rdata_d = '0;
		unique case (reg_addr)
			rxpc_pkg::OFS_CTRL: rdata_d = ctrl_q;
			rxpc_pkg::OFS_STATUS: rdata_d = status_q;
			rxpc_pkg::OFS_MASK: rdata_d = mask_q;
			rxpc_pkg::OFS_SEL: begin
				for (int ch = 0; ch < rxpc_pkg::NUM_CH; ch++) begin
					rdata_d[ch*rxpc_pkg::SEL_FIELD_W +: 3] = src_q[ch];
				end
				rdata_d[rxpc_pkg::SEL_IDENT_LSB] = all_ident;
				rdata_d[rxpc_pkg::SEL_IDENT_LSB + 1] = pair_ident;
			end
			default: rdata_d = '0;
		endcase
	end

	// read data one cycle after the strobe, zero otherwise
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			reg_rdata <= '0;
		end else begin
			reg_rdata <= reg_rd ? rdata_d : 32'h0000_0000;
		end
	end

	// interrupt level from unmasked sticky flags
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(status_d & mask_q);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	// every output comes straight from a register
	assign rd_word = rd_word_q;
	assign rd_valid = rd_valid_q;
	assign rd_src = src_q;
	assign rate_match_on = rm_q;
	assign irq = irq_q;

endmodule

/* File: dv/rxpc_monitor.sv */
// port checker for the receive fifo read clock block
`timescale 1ns/1ps
module rxpc_monitor (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire rxpc_pkg::rxpc_src_e [rxpc_pkg::NUM_CH-1:0] rd_src,
	input wire logic [rxpc_pkg::NUM_CH-1:0] rate_match_on,
	input wire logic irq
);
	logic [3:0] user_q;
	logic [7:0] mask_q;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	////////////////////////////////////////
	// shadow of user clock enables and mask
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			user_q <= 4'h0;
			mask_q <= 8'h00;
		end else if (reg_wr && reg_addr == 4'h0) begin
			user_q <= reg_wdata[7:4];
		end else if (reg_wr && reg_addr == 4'h8) begin
			mask_q <= reg_wdata[7:0];
		end
	end
	// selection and interrupt relations
	sequence s_quiet;
		(mask_q == 8'h00) [*3];
	endsequence
	sequence s_user;
		user_q[0] [*2];
	endsequence
	property p_quiet;
		s_quiet |-> !irq;
	endproperty
	a_quiet: assert property (p_quiet) else $error("irq with mask clear");
	property p_user;
		s_user |-> rd_src[0] == rxpc_pkg::SRC_USER;
	endproperty
	a_user: assert property (p_user) else $error("user clock ignored");
	property p_rx;
		rd_src[1] == rxpc_pkg::SRC_RX_OWN |-> !rate_match_on[1];
	endproperty
	a_rx: assert property (p_rx) else $error("own clock with matcher");
	property p_rm;
		rd_src[2] inside {rxpc_pkg::SRC_CORE_LOCAL, rxpc_pkg::SRC_CORE_MASTER} |-> rate_match_on[2];
	endproperty
	a_rm: assert property (p_rm) else $error("bonded without matcher");
	property p_x8;
		rd_src[0] == rxpc_pkg::SRC_CORE_MASTER |-> rd_src[3] inside {rxpc_pkg::SRC_CORE_MASTER, rxpc_pkg::SRC_USER};
	endproperty
	a_x8: assert property (p_x8) else $error("x8 split");
	property p_x4;
		rd_src[1] == rxpc_pkg::SRC_CORE_LOCAL |-> rd_src[2] inside {rxpc_pkg::SRC_CORE_LOCAL, rxpc_pkg::SRC_USER};
	endproperty
	a_x4: assert property (p_x4) else $error("x4 split");
	property p_all;
		rd_src[3] == rxpc_pkg::SRC_TX_CH0 |-> rd_src[0] inside {rxpc_pkg::SRC_TX_CH0, rxpc_pkg::SRC_USER};
	endproperty
	a_all: assert property (p_all) else $error("shared clock split");
	property p_pair;
		rd_src[2] == rxpc_pkg::SRC_TX_CH2 |-> rd_src[1] inside {rxpc_pkg::SRC_TX_CH0, rxpc_pkg::SRC_USER};
	endproperty
	a_pair: assert property (p_pair) else $error("pair split");
endmodule

bind rxpc_fifo_rdclk rxpc_monitor mon (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .rd_src, .rate_match_on, .irq);

/* File: dv/rxpc_fabric_model.sv */
// fabric side: locked read clocks and word capture
`timescale 1ns/1ps
module rxpc_fabric_model (
	input wire logic clk_sys,
	input wire logic [13:0] clk_en,
	input wire rxpc_pkg::rxpc_word_s [3:0] rd_word,
	input wire logic [3:0] rd_valid,
	output logic [13:0] rd_clks
);
	rxpc_pkg::rxpc_word_s got[4][$];
	logic [1:0] cnt = 2'h0;
	logic ph = 1'b0;
	logic [13:0] en_q = 14'h0;
	// clocks derived from clk_sys; enables move only while low
	always @(posedge clk_sys) begin
		cnt <= (cnt == 2'h2) ? 2'h0 : cnt + 2'h1;
		if (cnt == 2'h2)
			ph <= ~ph;
		if (!ph)
			en_q <= clk_en;
	end
	assign rd_clks = en_q & {14{ph}};
	// capture words on each clk_sys edge where rd_valid is high
	always @(posedge clk_sys) begin
		for (int i = 0; i < 4; i++)
			if (rd_valid[i])
				got[i].push_back(rd_word[i]);
	end
endmodule

/* File: dv/testbench.sv */
// self-checking bench for the receive fifo read clock block
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin num_errors++; $display("ERROR %0t %h %h", $time, a, b); end end
module testbench;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0, reg_rd = 1'b0;
	logic [31:0] reg_rdata, ctrl, d;
	rxpc_pkg::rxpc_cfg_s [3:0] cfg = '0;
	rxpc_pkg::rxpc_word_s [3:0] wr_word = '0, rd_word;
	rxpc_pkg::rxpc_word_s w;
	rxpc_pkg::rxpc_word_s exp_q[4][$];
	logic [3:0] wr_valid = 4'h0, rd_valid, rate_match_on;
	logic [13:0] clk_en = 14'h0, rclk, e;
	rxpc_pkg::rxpc_src_e [3:0] rd_src;
	logic irq;
	int num_errors = 0, comparisons = 0;
	logic [31:0] tbl[7] = '{32'h0000_0000, 32'h0000_0001, 32'h0000_0002, 32'h0000_00F0, 32'h0000_0100,
		32'h0000_0100, 32'h0000_0100};
	always #2.5 clk_sys = ~clk_sys;
	rxpc_fifo_rdclk uut (
		.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .chan_cfg(cfg), .wr_word, .wr_valid,
		.tx_par_clk(rclk[3:0]), .rx_rec_clk(rclk[7:4]), .user_rd_clk(rclk[11:8]), .core_clk_local(rclk[12]),
		.core_clk_master(rclk[13]), .rd_word, .rd_valid, .rd_src, .rate_match_on, .irq
	);
	rxpc_fabric_model fab (.clk_sys, .clk_en, .rd_word, .rd_valid, .rd_clks(rclk));
	////////////////////////////////////////
	// expected read clock source of a channel
	function automatic rxpc_pkg::rxpc_src_e exp_src(int i);
		logic same, pair;
		same = cfg[0] == cfg[1] && cfg[1] == cfg[2] && cfg[2] == cfg[3];
		pair = cfg[0] == cfg[1] && cfg[2] == cfg[3] && !cfg[0].pll_second && cfg[2].pll_second;
		if (ctrl[4 + i])
			return rxpc_pkg::SRC_USER;
		if (ctrl[1:0] == 2'h1)
			return rxpc_pkg::SRC_CORE_LOCAL;
		if (ctrl[1:0] == 2'h2)
			return rxpc_pkg::SRC_CORE_MASTER;
		if (!ctrl[8])
			return rxpc_pkg::SRC_RX_OWN;
		if (same)
			return rxpc_pkg::SRC_TX_CH0;
		if (pair)
			return i < 2 ? rxpc_pkg::SRC_TX_CH0 : rxpc_pkg::SRC_TX_CH2;
		return rxpc_pkg::SRC_TX_OWN;
	endfunction
	// clock line that should feed a channel
	function automatic int cbit(int i);
		int base[7] = '{0, 0, 2, 4, 12, 13, 8};
		int own[7] = '{1, 0, 0, 1, 0, 0, 1};
		rxpc_pkg::rxpc_src_e s;
		s = exp_src(i);
		return base[s] + own[s] * i;
	endfunction
	// expected selection readback word
	function automatic logic [31:0] exp_sel();
		logic [31:0] r;
		r = 32'h0;
		for (int i = 0; i < 4; i++)
			r[4 * i +: 3] = exp_src(i);
		r[16] = cfg[0] == cfg[1] && cfg[1] == cfg[2] && cfg[2] == cfg[3];
		r[17] = cfg[0] == cfg[1] && cfg[2] == cfg[3] && !cfg[0].pll_second && cfg[2].pll_second;
		return r;
	endfunction
	// register bus cycles
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] v);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	// channel setups: same, pairs, random, one bit apart
	task automatic setcfg(input int k);
		rxpc_pkg::rxpc_cfg_s a, b;
		d = $urandom;
		a = d[28:0];
		d = $urandom;
		b = d[28:0];
		a.pll_second = 1'b0;
		b.pll_second = 1'b1;
		@(posedge clk_sys);
		for (int i = 0; i < 4; i++) begin
			d = $urandom;
			cfg[i] <= k == 0 ? a : k == 1 ? (i < 2 ? a : b) : k == 2 ? d[28:0] : (i == 3 ? a ^ 29'h1 : a);
		end
		@(posedge clk_sys);
	endtask
	// write control, then check selection and readback
	task automatic setc(input logic [31:0] v);
		ctrl = v & 32'h0000_01F3;
		wr(4'h0, v);
		repeat (3) @(posedge clk_sys);
		#1;
		for (int i = 0; i < 4; i++) begin
			`CHK(rd_src[i], exp_src(i))
			`CHK(rate_match_on[i], ctrl[8] | ^ctrl[1:0])
		end
		rd(4'h0, d);
		`CHK(d, ctrl)
		rd(4'hC, d);
		`CHK(d, exp_sel())
	endtask
	// compare captured words with what was written
	task automatic chk_q();
		for (int i = 0; i < 4; i++) begin
			`CHK(fab.got[i].size(), exp_q[i].size())
			foreach (exp_q[i][j])
				`CHK(fab.got[i][j], exp_q[i][j])
			exp_q[i].delete();
			fab.got[i].delete();
		end
	endtask
	task automatic end_sim();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		#100000;
		num_errors++;
		end_sim();
	end
	// reset, selection sweep, data, overflow and interrupt
	initial begin
		d = $urandom(92044);
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		rd(4'h0, d);
		`CHK(d, rxpc_pkg::CTRL_RESET)
		rd(4'h8, d);
		`CHK(d, rxpc_pkg::MASK_RESET)
		rd(4'h2, d);
		`CHK(d, 32'h0000_0000)
		for (int n = 0; n < 24; n++) begin
			setcfg(n % 4);
			setc($urandom);
		end
		setcfg(1);
		setc(32'h0000_0100);
		foreach (tbl[t]) begin
			setcfg(t == 5 ? 1 : t == 6 ? 3 : 0);
			setc(tbl[t]);
			e = 14'h0;
			repeat (4) begin
				@(posedge clk_sys);
				for (int i = 0; i < 4; i++) begin
					d = $urandom;
					w = d[19:0];
					exp_q[i].push_back(w);
					wr_word[i] <= w;
					e[cbit(i)] = 1'b1;
				end
				wr_valid <= 4'hF;
			end
			@(posedge clk_sys);
			wr_valid <= 4'h0;
			clk_en <= e;
			repeat (60) @(posedge clk_sys);
			clk_en <= 14'h0;
			repeat (8) @(posedge clk_sys);
			chk_q();
		end
		setc(32'h0000_0000);
		rd(4'h4, d);
		wr(4'h8, 32'h0000_0001);
		repeat (9) begin
			@(posedge clk_sys);
			d = $urandom;
			w = d[19:0];
			if (exp_q[0].size() < 8)
				exp_q[0].push_back(w);
			wr_word[0] <= w;
			wr_valid <= 4'h1;
		end
		@(posedge clk_sys);
		wr_valid <= 4'h0;
		repeat (2) @(posedge clk_sys);
		#1;
		`CHK(irq, 1'b1)
		rd(4'h4, d);
		`CHK(d, 32'h0000_0001)
		repeat (2) @(posedge clk_sys);
		#1;
		`CHK(irq, 1'b0)
		wr(4'h8, 32'h0000_0000);
		clk_en <= 14'h0010;
		repeat (80) @(posedge clk_sys);
		#1;
		`CHK(irq, 1'b0)
		rd(4'h4, d);
		`CHK(d, 32'h0000_0010)
		clk_en <= 14'h0;
		chk_q();
		end_sim();
	end
endmodule
